// [rtl/tmcc_map.vh]
// register offsets, field positions and reset values of the timer compare block
`ifndef TMCC_MAP_VH
`define TMCC_MAP_VH
`define TMCC_FLAGS_OFS 8'h36
`define TMCC_FLAGS_IO_OFS 8'h16
`define TMCC_IO_BASE 8'h20
`define TMCC_ENABLES_OFS 8'h6f
`define TMCC_CAP_LOW_OFS 8'h86
`define TMCC_CAP_HIGH_OFS 8'h87
`define TMCC_CMPA_LOW_OFS 8'h88
`define TMCC_CMPA_HIGH_OFS 8'h89
`define TMCC_CMPB_LOW_OFS 8'h8a
`define TMCC_CMPB_HIGH_OFS 8'h8b
`define TMCC_BIT_CAP 5
`define TMCC_BIT_MB 2
`define TMCC_BIT_MA 1
`define TMCC_BIT_OVF 0
`define TMCC_FLAGS_MASK 8'h27
`define TMCC_RESET_BYTE 8'h00
`define TMCC_RESET_WORD 16'h0000
`define TMCC_MODE_NORMAL 4'h0
`define TMCC_MODE_CLR_A 4'h4
`define TMCC_MODE_CLR_CAP 4'hc
`define TMCC_MODE_FAST_CAP 4'he
`endif

// [rtl/tmcc_match.v]
// one compare channel: equality detect and match event pulse
`timescale 1ns/100ps
`default_nettype none
module tmcc_match (
	// clock and reset
	input wire clk,
	input wire rst,
	// compare inputs
	input wire timer_tick,
	input wire cnt_write,
	input wire [15:0] counter_value,
	input wire [15:0] compare_value,
	// result
	output reg equal_q,
	output reg match_q
);
	wire equal_d;
	reg armed_q;
	assign equal_d = (counter_value == compare_value); // R01
	always @(posedge clk) begin
		if (rst) begin
			equal_q <= 1'b0;
			match_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			equal_q <= equal_d;
			// counter write blocks the match on the next timer clock
			if (cnt_write)
				armed_q <= 1'b0;
			else if (timer_tick)
				armed_q <= 1'b1;
			// flag event lands on the timer clock after equality
			match_q <= timer_tick & equal_q & armed_q & ~cnt_write; // R14 R15
		end
	end
endmodule // tmcc_match
`default_nettype wire

// [rtl/tmcc_top.v]
// compare, capture and interrupt flag logic of the 16-bit timer
//
// Functional notes
// R01: compare registers continuously checked against counter
// R02: match drives interrupt and waveform pin
// R03: byte writes go through temporary high byte
// R04: one temporary byte shared by all registers
// R05: software writes high byte before low byte
// R06: low read latches high byte for later
// R07: capture irq needs enable bit 5, global, flag
// R08: match irqs need enable, global, flag
// R09: overflow irq needs bit 0, global, flag
// R10: capture event sets capture flag bit 5
// R11: top at capture register sets capture flag
// R12: capture flag clears on vector execution
// R13: writing one clears capture flag
// R14: match b flag set timer clock after equality
// R15: match a flag set timer clock after equality
// R16: forced compare never sets match flag
// R17: match flags clear by vector or write one
// R18: overflow flag set in normal, clear-on-match modes
// R19: overflow flag clears by vector or one
// R20: flag register at data and io offsets
// R21: capture event copies counter into capture register
// R22: capture pin ignored when capture is top
`timescale 1ns/100ps
`default_nettype none
`include "tmcc_map.vh"
module tmcc_top (
	// clock and reset
	input wire clk,
	input wire rst,
	// internal register bus
	input wire [7:0] bus_addr,
	input wire bus_io_space,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] bus_wdata,
	output reg [7:0] bus_rdata_q,
	// counter core
	input wire [15:0] counter_value,
	input wire timer_tick,
	input wire cnt_write,
	input wire counter_overflow,
	input wire counter_at_top,
	input wire [3:0] waveform_mode_sel,
	input wire force_match_a,
	input wire force_match_b,
	// capture sources
	input wire capture_event,
	input wire capture_from_comparator,
	input wire comparator_event,
	// interrupt controller
	input wire global_irq_en,
	input wire vec_ack_capture,
	input wire vec_ack_match_a,
	input wire vec_ack_match_b,
	input wire vec_ack_overflow,
	output reg irq_capture_q,
	output reg irq_match_a_q,
	output reg irq_match_b_q,
	output reg irq_overflow_q,
	// waveform unit
	output reg wave_strobe_a_q,
	output reg wave_strobe_b_q,
	output reg [15:0] capture_value_q,
	output reg [15:0] top_compare_a_q
);
	reg [7:0] temp_high_q;
	reg [15:0] compare_a_value_q;
	reg [15:0] compare_b_value_q;
	reg [7:0] timer16_irq_enables_q;
	reg [7:0] timer16_event_flags_q;
	reg [7:0] flags_d;
	reg [7:0] rdata_d;
	wire [7:0] eff_addr;
	wire [7:0] dec_addr;
	wire [1:0] match_q;
	wire [1:0] equal_q;
	wire cap_is_top;
	wire cap_trigger;
	wire ovf_mode;
	wire wr_flags;
	wire wr_cap_l;
	wire wr_cap_h;
	wire wr_a_l;
	wire wr_a_h;
	wire wr_b_l;
	wire wr_b_h;
	wire [15:0] cmp_vals [0:1];

	// io-space accesses are rebased into data space
	assign eff_addr = bus_addr + `TMCC_IO_BASE;
	assign dec_addr = bus_io_space ? eff_addr : bus_addr; // R20
	assign wr_flags = bus_wr & (dec_addr == `TMCC_FLAGS_OFS); // R20
	assign wr_cap_l = bus_wr & (dec_addr == `TMCC_CAP_LOW_OFS);
	assign wr_cap_h = bus_wr & (dec_addr == `TMCC_CAP_HIGH_OFS);
	assign wr_a_l = bus_wr & (dec_addr == `TMCC_CMPA_LOW_OFS);
	assign wr_a_h = bus_wr & (dec_addr == `TMCC_CMPA_HIGH_OFS);
	assign wr_b_l = bus_wr & (dec_addr == `TMCC_CMPB_LOW_OFS);
	assign wr_b_h = bus_wr & (dec_addr == `TMCC_CMPB_HIGH_OFS);

	assign cap_is_top = (waveform_mode_sel == `TMCC_MODE_CLR_CAP) |
		(waveform_mode_sel == `TMCC_MODE_FAST_CAP);
	// pin disconnected when capture value is top
	assign cap_trigger = ~cap_is_top & (capture_from_comparator ?
		comparator_event : capture_event); // R21 R22
	// other modes report overflow through counter_at_top path
	assign ovf_mode = (waveform_mode_sel == `TMCC_MODE_NORMAL) |
		(waveform_mode_sel == `TMCC_MODE_CLR_A); // R18

	assign cmp_vals[0] = compare_a_value_q;
	assign cmp_vals[1] = compare_b_value_q;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_chan
			tmcc_match u_match (
				.clk(clk),
				.rst(rst),
				.timer_tick(timer_tick),
				.cnt_write(cnt_write),
				.counter_value(counter_value),
				.compare_value(cmp_vals[g]),
				.equal_q(equal_q[g]),
				.match_q(match_q[g])
			);
		end
	endgenerate

	// 16-bit registers and shared temporary byte
	always @(posedge clk) begin
		if (rst) begin
			temp_high_q <= `TMCC_RESET_BYTE;
			compare_a_value_q <= `TMCC_RESET_WORD;
			compare_b_value_q <= `TMCC_RESET_WORD;
			capture_value_q <= `TMCC_RESET_WORD;
			timer16_irq_enables_q <= `TMCC_RESET_BYTE;
		end else begin
			// high write only parks the byte in the shared temp
			if (wr_cap_h | wr_a_h | wr_b_h)
				temp_high_q <= bus_wdata; // R03 R04 R05
			else if (bus_rd & (dec_addr == `TMCC_CAP_LOW_OFS))
				temp_high_q <= capture_value_q[15:8]; // R06
			else if (bus_rd & (dec_addr == `TMCC_CMPA_LOW_OFS))
				temp_high_q <= compare_a_value_q[15:8]; // R06
			else if (bus_rd & (dec_addr == `TMCC_CMPB_LOW_OFS))
				temp_high_q <= compare_b_value_q[15:8]; // R06
			if (wr_a_l)
				compare_a_value_q <= {temp_high_q, bus_wdata}; // R03
			if (wr_b_l)
				compare_b_value_q <= {temp_high_q, bus_wdata}; // R03
			// software write wins over a same-cycle capture
			if (wr_cap_l)
				capture_value_q <= {temp_high_q, bus_wdata};
			else if (cap_trigger)
				capture_value_q <= counter_value; // R21
			if (bus_wr & (dec_addr == `TMCC_ENABLES_OFS))
				timer16_irq_enables_q <= bus_wdata & `TMCC_FLAGS_MASK;
		end
	end

	// flags: hardware set wins over a same-cycle clear
	always @* begin
		flags_d = timer16_event_flags_q;
		if (wr_flags)
			flags_d = flags_d & ~bus_wdata; // R13 R17 R19
		if (vec_ack_capture)
			flags_d[`TMCC_BIT_CAP] = 1'b0; // R12
		if (vec_ack_match_a)
			flags_d[`TMCC_BIT_MA] = 1'b0; // R17
		if (vec_ack_match_b)
			flags_d[`TMCC_BIT_MB] = 1'b0; // R17
		if (vec_ack_overflow)
			flags_d[`TMCC_BIT_OVF] = 1'b0; // R19
		if (cap_trigger)
			flags_d[`TMCC_BIT_CAP] = 1'b1; // R10
		if (cap_is_top & counter_at_top & timer_tick)
			flags_d[`TMCC_BIT_CAP] = 1'b1; // R11
		// force strobes never reach the flag path
		if (match_q[0])
			flags_d[`TMCC_BIT_MA] = 1'b1; // R15 R16
		if (match_q[1])
			flags_d[`TMCC_BIT_MB] = 1'b1; // R14 R16
		if ((ovf_mode & counter_overflow) |
			(~ovf_mode & counter_at_top & timer_tick))
			flags_d[`TMCC_BIT_OVF] = 1'b1; // R18
		flags_d = flags_d & `TMCC_FLAGS_MASK;
	end

	// read mux; high bytes of capture and compares come from temp
	always @* begin
		rdata_d = `TMCC_RESET_BYTE;
		if (bus_rd) begin
			case (dec_addr)
			`TMCC_FLAGS_OFS: rdata_d = timer16_event_flags_q; // R20
			`TMCC_ENABLES_OFS: rdata_d = timer16_irq_enables_q;
			`TMCC_CAP_LOW_OFS: rdata_d = capture_value_q[7:0];
			`TMCC_CMPA_LOW_OFS: rdata_d = compare_a_value_q[7:0];
			`TMCC_CMPB_LOW_OFS: rdata_d = compare_b_value_q[7:0];
			`TMCC_CAP_HIGH_OFS: rdata_d = temp_high_q; // R06
			`TMCC_CMPA_HIGH_OFS: rdata_d = temp_high_q; // R06
			`TMCC_CMPB_HIGH_OFS: rdata_d = temp_high_q; // R06
			default: rdata_d = `TMCC_RESET_BYTE;
			endcase
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			timer16_event_flags_q <= `TMCC_RESET_BYTE;
			bus_rdata_q <= `TMCC_RESET_BYTE;
			irq_capture_q <= 1'b0;
			irq_match_a_q <= 1'b0;
			irq_match_b_q <= 1'b0;
			irq_overflow_q <= 1'b0;
			wave_strobe_a_q <= 1'b0;
			wave_strobe_b_q <= 1'b0;
			top_compare_a_q <= `TMCC_RESET_WORD;
		end else begin
			timer16_event_flags_q <= flags_d;
			bus_rdata_q <= rdata_d;
			// requests follow registered flags; one cycle behind
			irq_capture_q <= global_irq_en &
				timer16_irq_enables_q[`TMCC_BIT_CAP] &
				timer16_event_flags_q[`TMCC_BIT_CAP]; // R07
			irq_match_a_q <= global_irq_en &
				timer16_irq_enables_q[`TMCC_BIT_MA] &
				timer16_event_flags_q[`TMCC_BIT_MA]; // R08
			irq_match_b_q <= global_irq_en &
				timer16_irq_enables_q[`TMCC_BIT_MB] &
				timer16_event_flags_q[`TMCC_BIT_MB]; // R08
			irq_overflow_q <= global_irq_en &
				timer16_irq_enables_q[`TMCC_BIT_OVF] &
				timer16_event_flags_q[`TMCC_BIT_OVF]; // R09
			// waveform strobe takes match or force
			wave_strobe_a_q <= match_q[0] | force_match_a; // R02
			wave_strobe_b_q <= match_q[1] | force_match_b; // R02
			top_compare_a_q <= compare_a_value_q;
		end
	end

	// equality levels are not output; match pulses and force strobes reach the waveform unit
	wire unused_eq;
	assign unused_eq = &equal_q;
endmodule // tmcc_top
`default_nettype wire

// [dv/tmcc_props.sv]
// port assertions of the timer compare block
`timescale 1ns/100ps
`default_nettype none
module tmcc_props (
	// clock and bus
	input wire logic clk,
	input wire logic rst,
	input wire logic bus_rd,
	input wire logic bus_wr,
	input wire logic [7:0] bus_rdata_q,
	// counter side
	input wire logic [15:0] counter_value,
	input wire logic [3:0] waveform_mode_sel,
	input wire logic force_match_a,
	input wire logic counter_overflow,
	input wire logic capture_event,
	input wire logic capture_from_comparator,
	input wire logic counter_at_top,
	// interrupt side
	input wire logic global_irq_en,
	input wire logic vec_ack_capture,
	input wire logic vec_ack_overflow,
	input wire logic irq_capture_q,
	input wire logic irq_match_a_q,
	input wire logic irq_overflow_q,
	// outputs
	input wire logic wave_strobe_a_q,
	input wire logic [15:0] capture_value_q
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
// capture pin is dead while capture value is the top
sequence s_cap_live;
	capture_event && !bus_wr && !capture_from_comparator &&
		!(waveform_mode_sel inside {4'hc, 4'he});
endsequence
// a set in the ack cycle wins, so only a clean ack must drop the request
sequence s_cap_ack;
	vec_ack_capture && !capture_event && !counter_at_top ##1 1'b1;
endsequence
chk_global_gates_irq: assert property (!global_irq_en [*2] |-> !irq_match_a_q && !irq_capture_q)
	else $error("irq while globally off");
chk_rdata_idle: assert property (!bus_rd |=> bus_rdata_q == 8'h00)
	else $error("read data without read");
chk_force_strobe: assert property (force_match_a |-> ##[1:2] wave_strobe_a_q)
	else $error("forced strobe missing");
chk_capture_copy: assert property (s_cap_live |=> capture_value_q == $past(counter_value))
	else $error("capture value not copied");
chk_capture_top: assert property (capture_event && !bus_wr && waveform_mode_sel == 4'hc |=> $stable(capture_value_q))
	else $error("capture in top mode");
chk_ack_cap_irq: assert property (s_cap_ack |=> !irq_capture_q)
	else $error("capture irq after ack");
chk_ack_ovf_irq: assert property (vec_ack_overflow && !counter_overflow && !counter_at_top |=> ##1 !irq_overflow_q)
	else $error("overflow irq after ack");
chk_ovf_irq_global: assert property ($rose(irq_overflow_q) |-> $past(global_irq_en))
	else $error("overflow irq without global");
endmodule // tmcc_props
bind tmcc_top tmcc_props u_props (.*);
`default_nettype wire

// [dv/tmcc_cpu_model.sv]
// processor core model on the internal register bus
`timescale 1ns/100ps
`default_nettype none
module tmcc_cpu_model (
	input wire logic clk,
	input wire logic [7:0] bus_rdata_q,
	output logic [7:0] bus_addr,
	output logic bus_io_space,
	output logic bus_wr,
	output logic bus_rd,
	output logic [7:0] bus_wdata
);
initial begin
	bus_addr = 8'h00;
	bus_io_space = 1'b0;
	bus_wr = 1'b0;
	bus_rd = 1'b0;
	bus_wdata = 8'h00;
end
// callers send high byte before low byte
task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
	bus_io_space = io;
	bus_addr = a;
	bus_wdata = d;
	bus_wr = 1'b1;
	@(posedge clk);
	#1;
	bus_wr = 1'b0;
	bus_wdata = ~d; // stale data must not look valid
	@(posedge clk);
	#1;
endtask
task automatic rd(input logic io, input logic [7:0] a, output logic [7:0] d);
	bus_io_space = io;
	bus_addr = a;
	bus_rd = 1'b1;
	@(posedge clk);
	#1;
	bus_rd = 1'b0;
	d = bus_rdata_q;
	bus_addr = ~a;
	@(posedge clk);
	#1;
endtask
endmodule // tmcc_cpu_model
`default_nettype wire

// [dv/tmcc_top_tb.sv]
// self-checking testbench of the timer compare block
`timescale 1ns/100ps
`default_nettype none
module tmcc_top_tb;
logic clk, rst, bus_io_space, bus_wr, bus_rd, timer_tick, cnt_write;
logic counter_overflow, counter_at_top, force_match_a, force_match_b;
logic capture_event, capture_from_comparator, comparator_event;
logic global_irq_en, vec_ack_capture, vec_ack_match_a, vec_ack_match_b;
logic vec_ack_overflow, irq_capture_q, irq_match_a_q, irq_match_b_q;
logic irq_overflow_q, wave_strobe_a_q, wave_strobe_b_q;
logic [7:0] bus_addr, bus_wdata, bus_rdata_q;
logic [15:0] counter_value, capture_value_q, top_compare_a_q;
logic [3:0] waveform_mode_sel;
int check_count = 0;
int bad_count = 0;
tmcc_top uut (.*);
tmcc_cpu_model cpu (.*);
task report_and_stop;
	$display("checks %0d mismatches %0d", check_count, bad_count);
	if (bad_count == 0 && check_count > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
	check_count++;
	if (s !== e) begin
		bad_count++;
		$display("BAD %s expected %h seen %h", w, e, s);
	end
endtask
task automatic rdc(input logic io, input logic [7:0] a, input logic [7:0] e);
	logic [7:0] d;
	cpu.rd(io, a, d);
	chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, e});
endtask
task automatic cyc(input int n);
	repeat (n) @(posedge clk);
	#1;
endtask
task t_compare;
	force_match_a = 1;
	force_match_b = 1;
	cyc(1);
	chk("strobes", 16'({wave_strobe_a_q, wave_strobe_b_q}), 16'h3);
	force_match_a = 0;
	force_match_b = 0;
	cyc(4);
	rdc(0, 8'h36, 8'h00);
	cpu.wr(0, 8'h89, 8'h12);
	cpu.wr(0, 8'h88, 8'h34);
	cpu.wr(0, 8'h8b, 8'h56);
	cpu.wr(0, 8'h8a, 8'h78);
	chk("cmp a", top_compare_a_q, 16'h1234);
	rdc(0, 8'h88, 8'h34);
	rdc(0, 8'h89, 8'h12);
	counter_value = 16'h1234;
	cyc(1);
	counter_value = 16'hffff;
	cyc(4);
	rdc(1, 8'h16, 8'h02);
	counter_value = 16'h5678;
	cyc(1);
	counter_value = 16'hffff;
	cyc(4);
	rdc(0, 8'h36, 8'h06);
	cpu.wr(0, 8'h6f, 8'h06);
	global_irq_en = 1;
	cyc(2);
	chk("irq ab", 16'({irq_match_a_q, irq_match_b_q}), 16'h3);
	global_irq_en = 0;
	vec_ack_match_a = 1;
	vec_ack_match_b = 1;
	cyc(1);
	vec_ack_match_a = 0;
	vec_ack_match_b = 0;
	rdc(0, 8'h36, 8'h00);
	$display("compare test done");
endtask
task t_capture;
	for (int m = 1; m >= 0; m--) begin
		waveform_mode_sel = m ? 4'hc : 4'h0;
		counter_value = m ? 16'h1111 : 16'habcd;
		capture_event = 1;
		cyc(1);
		capture_event = 0;
		counter_value = 16'hffff;
		cyc(2);
		chk("cap", capture_value_q, m ? 16'h0000 : 16'habcd);
		rdc(0, 8'h36, m ? 8'h00 : 8'h20);
	end
	waveform_mode_sel = 4'h0;
	rdc(0, 8'h86, 8'hcd);
	rdc(0, 8'h87, 8'hab);
	cpu.wr(0, 8'h36, 8'h00);
	rdc(0, 8'h36, 8'h20);
	cpu.wr(0, 8'h6f, 8'h20);
	global_irq_en = 1;
	cyc(2);
	chk("irq cap", 16'(irq_capture_q), 16'h1);
	vec_ack_capture = 1;
	cyc(1);
	vec_ack_capture = 0;
	cyc(2);
	chk("irq cap off", 16'(irq_capture_q), 16'h0);
	$display("capture test done");
endtask
task t_overflow;
	for (int m = 0; m < 3; m++) begin
		waveform_mode_sel = m == 1 ? 4'h4 : 4'h0;
		global_irq_en = m == 2;
		cpu.wr(0, 8'h6f, m == 2 ? 8'h01 : 8'h00);
		counter_overflow = 1;
		cyc(1);
		counter_overflow = 0;
		cyc(2);
		chk("irq ovf", 16'(irq_overflow_q), 16'(m == 2));
		rdc(0, 8'h36, 8'h01);
		vec_ack_overflow = m == 2;
		cyc(1);
		vec_ack_overflow = 0;
		cpu.wr(0, 8'h36, 8'h01);
		rdc(0, 8'h36, 8'h00);
	end
	waveform_mode_sel = 4'hc;
	counter_at_top = 1;
	cyc(1);
	counter_at_top = 0;
	waveform_mode_sel = 4'h0;
	cyc(1);
	rdc(0, 8'h36, 8'h21);
	cpu.wr(0, 8'h36, 8'h21);
	rdc(0, 8'h36, 8'h00);
	$display("overflow test done");
endtask
initial begin
	clk = 1'b0;
	forever #12.5 clk = ~clk;
end
initial begin
	#(25 * 3000);
	bad_count++;
	report_and_stop();
end
initial begin
	{cnt_write, counter_at_top, capture_from_comparator} = '0;
	{comparator_event, counter_overflow, force_match_a, force_match_b} = '0;
	{capture_event, global_irq_en, vec_ack_capture, vec_ack_match_a} = '0;
	{vec_ack_match_b, vec_ack_overflow} = '0;
	timer_tick = 1;
	rst = 1;
	counter_value = 16'hffff;
	waveform_mode_sel = 4'h0;
	cyc(2);
	rst = 0;
	cyc(1);
	rdc(0, 8'h36, 8'h00);
	cpu.wr(0, 8'h6f, 8'hff);
	rdc(0, 8'h6f, 8'h27);
	rdc(0, 8'h90, 8'h00);
	$display("reset test done");
	t_compare();
	t_capture();
	t_overflow();
	report_and_stop();
end
endmodule // tmcc_top_tb
`default_nettype wire
